// *** rtl/itc_pkg.sv ***
/*
 * itc_pkg: register map, field positions, reset values and decode
 * functions shared by the transfer-length and scl control block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
package itc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TCC = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TCC_BC_LSB = 5;
    localparam int TCC_ACK_BIT = 4;
    localparam int TCC_ONE_BIT = 3;
    localparam int TCC_SCK_LSB = 0;
    localparam int CTRL_MASTER_BIT = 7;
    localparam int CTRL_START_BIT = 5;
    localparam int CTRL_DONE_CLR_BIT = 4;
    localparam int CTRL_SRST_LSB = 0;
    localparam int STAT_DONE_BIT = 2;
    localparam int STAT_BUSY_BIT = 1;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [2:0] BC_RST = 3'h0;
    localparam logic [2:0] SCK_RST = 3'h0;
    localparam logic [7:0] TX_RST = 8'hff;
    localparam logic [1:0] SRST_ARM = 2'h2;
    localparam logic [1:0] SRST_FIRE = 2'h1;
    localparam logic [2:0] SRST_CYCLES = 3'h4;
    localparam logic [3:0] N_BASE = 4'h5;
    localparam logic [3:0] N_MAX = 4'hb;
    localparam logic [12:0] DIV_BASE = 13'h048;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // data bits for a length code: 000 is a full byte
    function automatic logic [3:0] itc_data_bits(input logic [2:0] bc);
        itc_data_bits = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
    endfunction

    // scl half period in system clocks: (2^n + 72) / 2
    function automatic logic [11:0] itc_half(input logic [2:0] sck);
        logic [3:0] n;
        logic [12:0] p;
        n = (sck == 3'h7) ? N_MAX : ({1'b0, sck} + N_BASE);
        p = (13'h0001 << n) + DIV_BASE;
        itc_half = p[12:1];
    endfunction

endpackage

// *** rtl/itc_slave_count.sv ***
/*
 * itc_slave_count: slave-mode bit counter clocked by the incoming scl.
 * Assumes length and acknowledge settings are static while scl runs,
 * and that sda is stable at each scl rising edge as the bus demands.
 */
`timescale 1ns/1ps
module itc_slave_count
    import itc_pkg::*;
(
    input wire logic link_clk, // scl from the bus
    input wire logic clear_req, // level from system domain, high clears
    input wire logic sda_in, // sda pin level
    input wire logic [2:0] bit_count_sel, // length code
    input wire logic ack_on, // acknowledge clock counted
    output logic [7:0] rx_data, // last received data, held
    output logic done_tgl // flips once per completed transfer
);

    logic clr_s1_r;
    logic clr_s2_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    wire [3:0] data_bits = itc_data_bits(bit_count_sel);
    wire [3:0] total = data_bits + {3'h0, ack_on};
    wire last_clk = (cnt_r == total - 4'h1);
    wire data_clk = (cnt_r < data_bits);
    wire [7:0] sh_nxt = data_clk ? {sh_r[6:0], sda_in} : sh_r;

    // ------------------------------------------------------------
    // clear crossing and counting
    // ------------------------------------------------------------
    always_ff @(posedge link_clk) begin
        clr_s1_r <= clear_req;
        clr_s2_r <= clr_s1_r;
    end

    always_ff @(posedge link_clk) begin
        if (clr_s2_r) begin
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rx_data <= 8'h00;
            done_tgl <= 1'b0;
        end else if (last_clk) begin
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            rx_data <= sh_nxt;
            done_tgl <= ~done_tgl;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            sh_r <= sh_nxt;
        end
    end

    chk_slave_frame_end: assert property (@(posedge link_clk) disable iff (clr_s2_r)
        $changed(done_tgl) |-> $past(cnt_r) == $past(total) - 4'h1)
        else $error("slave transfer ended at wrong clock count");

endmodule

// *** rtl/itc_top.sv ***
/*
 * itc_top: transfer length and scl control for one two-wire channel,
 * with AXI4-Lite register access, master clock generation, and a
 * slave-side counter in the scl clock domain.
 * Assumes open-drain pads resolved outside; scl also feeds link_clk.
 */
//
// Contract
// - length code 000 gives 8 data bits, 001..111 give 1..7, and acknowledge adds one clock.
// - as master an acknowledge clock follows the data only when the acknowledge bit is set.
// - as slave the acknowledge clock is counted in the transfer only when the acknowledge bit is set.
// - the frequency code 000..110 picks n of 5..11, 111 is reserved, scl is sysclk over (2^n + 72).
// - the low frequency bit is write only, reading it returns 0 during soft reset and 1 otherwise.
// - after reset the working frequency code is 000 though the low bit reads 1.
// - writing 10 then 01 to the reset trigger starts a soft reset, the monitor reads 0 until done.
`timescale 1ns/1ps
module itc_top
    import itc_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, low active
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic link_clk, // scl as clock for slave counting
    input wire logic sda_i, // sda pin level
    output logic sda_o, // sda drive value, always low
    output logic sda_oe, // sda pulled low when high
    output logic scl_o, // scl drive value, always low
    output logic scl_oe // scl pulled low when high
);

    typedef enum logic [1:0] {
        ITC_IDLE = 2'b00,
        ITC_LOW = 2'b01,
        ITC_HIGH = 2'b10
    } itc_state_e;

    function automatic logic itc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        itc_hit = (a == ADDR_W'(ofs));
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [2:0] bc_r;
    logic ack_r;
    logic [2:0] sck_r;
    logic master_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic last_bit_r;
    logic done_r;
    logic srst_armed_r;
    logic srst_busy_r;
    logic [2:0] srst_cnt_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic aw_got_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_got_r;
    itc_state_e state_r;
    logic [11:0] ph_cnt_r;
    logic [3:0] bit_cnt_r;
    logic [3:0] total_r;
    logic ack_lat_r;
    logic [7:0] tx_sh_r;
    logic sda_s1_r;
    logic sda_s2_r;
    logic dt_s1_r;
    logic dt_s2_r;
    logic dt_s3_r;
    logic [7:0] slv_data;
    logic slv_tgl;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    wire wr_b0 = wr_fire && wstrb_r[0];
    wire wr_tcc = wr_b0 && itc_hit(awaddr_r, OFS_TCC);
    wire wr_data = wr_b0 && itc_hit(awaddr_r, OFS_DATA);
    wire wr_ctrl = wr_b0 && itc_hit(awaddr_r, OFS_CTRL);
    wire wr_ok = itc_hit(awaddr_r, OFS_TCC) || itc_hit(awaddr_r, OFS_DATA) || itc_hit(awaddr_r, OFS_CTRL);
    wire [1:0] trig = wdata_r[CTRL_SRST_LSB +: 2];
    wire srst_go = wr_ctrl && srst_armed_r && (trig == SRST_FIRE);
    wire start = wr_ctrl && wdata_r[CTRL_START_BIT] && master_r && !srst_busy_r;
    wire done_clr = wr_ctrl && wdata_r[CTRL_DONE_CLR_BIT];
    wire m_busy = (state_r != ITC_IDLE);
    wire slv_done = dt_s2_r ^ dt_s3_r;
    wire [11:0] half = itc_half(sck_r);
    wire ph_end = (ph_cnt_r == 12'h001);
    wire last_clk = (bit_cnt_r == 4'h1);
    wire next_ack = ack_lat_r && (bit_cnt_r == 4'h2);
    wire rd_ack = s_axi_arvalid && s_axi_arready;
    wire [31:0] tcc_rd = {24'h0, bc_r, ack_r, 1'b1, sck_r[2:1], ~srst_busy_r};
    wire [31:0] data_rd = {24'h0, rx_r};
    wire [31:0] ctrl_rd = {24'h0, master_r, 4'h0, done_r, m_busy, last_bit_r};
    wire rd_tcc = itc_hit(s_axi_araddr, OFS_TCC);
    wire rd_data = itc_hit(s_axi_araddr, OFS_DATA);
    wire rd_ctrl = itc_hit(s_axi_araddr, OFS_CTRL);
    wire [31:0] rd_word = rd_tcc ? tcc_rd : rd_data ? data_rd : rd_ctrl ? ctrl_rd : 32'h0;
    wire rd_ok = rd_tcc || rd_data || rd_ctrl;

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                aw_got_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_got_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (rd_ack) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // configuration and soft reset
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bc_r <= BC_RST;
            ack_r <= 1'b0;
            sck_r <= SCK_RST;
            master_r <= 1'b0;
            tx_r <= TX_RST;
        end else begin
            if (wr_tcc) begin
                bc_r <= wdata_r[TCC_BC_LSB +: 3];
                ack_r <= wdata_r[TCC_ACK_BIT];
                sck_r <= wdata_r[TCC_SCK_LSB +: 3];
            end
            if (wr_ctrl) begin
                master_r <= wdata_r[CTRL_MASTER_BIT];
            end
            if (wr_data) begin
                tx_r <= wdata_r[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            srst_armed_r <= 1'b0;
            srst_busy_r <= 1'b0;
            srst_cnt_r <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                srst_armed_r <= (trig == SRST_ARM);
            end
            if (srst_go) begin
                srst_busy_r <= 1'b1;
                srst_cnt_r <= SRST_CYCLES - 3'h1;
            end else if (srst_busy_r) begin
                srst_cnt_r <= srst_cnt_r - 3'h1;
                srst_busy_r <= (srst_cnt_r != 3'h0);
            end
        end
    end

    // ------------------------------------------------------------
    // master clock and data engine
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        sda_s1_r <= sda_i;
        sda_s2_r <= sda_s1_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || srst_busy_r) begin
            state_r <= ITC_IDLE;
            ph_cnt_r <= 12'h0;
            bit_cnt_r <= 4'h0;
            total_r <= 4'h0;
            ack_lat_r <= 1'b0;
            tx_sh_r <= TX_RST;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            unique case (state_r)
                ITC_IDLE: begin
                    if (start) begin
                        state_r <= ITC_LOW;
                        ph_cnt_r <= half;
                        bit_cnt_r <= itc_data_bits(bc_r) + {3'h0, ack_r};
                        total_r <= itc_data_bits(bc_r) + {3'h0, ack_r};
                        ack_lat_r <= ack_r;
                        tx_sh_r <= {tx_r[6:0], 1'b1};
                        scl_oe <= 1'b1;
                        sda_oe <= !tx_r[7];
                    end
                end
                ITC_LOW: begin
                    ph_cnt_r <= ph_cnt_r - 12'h001;
                    if (ph_end) begin
                        state_r <= ITC_HIGH;
                        ph_cnt_r <= half;
                        scl_oe <= 1'b0;
                    end
                end
                ITC_HIGH: begin
                    ph_cnt_r <= ph_cnt_r - 12'h001;
                    if (ph_end) begin
                        bit_cnt_r <= bit_cnt_r - 4'h1;
                        ph_cnt_r <= half;
                        if (last_clk) begin
                            state_r <= ITC_IDLE;
                            sda_oe <= 1'b0;
                        end else begin
                            state_r <= ITC_LOW;
                            scl_oe <= 1'b1;
                            sda_oe <= !next_ack && !tx_sh_r[7];
                            tx_sh_r <= {tx_sh_r[6:0], 1'b1};
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive capture and slave result crossing
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dt_s1_r <= 1'b0;
            dt_s2_r <= 1'b0;
            dt_s3_r <= 1'b0;
        end else begin
            dt_s1_r <= slv_tgl;
            dt_s2_r <= dt_s1_r;
            dt_s3_r <= dt_s2_r;
        end
    end

    wire sample = (state_r == ITC_LOW) && ph_end;
    wire m_done = (state_r == ITC_HIGH) && ph_end && last_clk;

    always_ff @(posedge aclk) begin
        if (!aresetn || srst_busy_r) begin
            rx_r <= 8'h00;
            last_bit_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            if (sample && last_clk && ack_lat_r) begin
                last_bit_r <= sda_s2_r;
            end else if (sample) begin
                rx_r <= {rx_r[6:0], sda_s2_r};
            end else if (slv_done && !master_r) begin
                rx_r <= slv_data;
            end
            done_r <= m_done || (slv_done && !master_r) || (done_r && !done_clr);
        end
    end

    always_ff @(posedge aclk) begin
        scl_o <= 1'b0;
        sda_o <= 1'b0;
    end

    itc_slave_count u_slave (
        .link_clk(link_clk),
        .clear_req(!aresetn || srst_busy_r || master_r),
        .sda_in(sda_i),
        .bit_count_sel(bc_r),
        .ack_on(ack_r),
        .rx_data(slv_data),
        .done_tgl(slv_tgl)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [11:0] lo_len_r;
    logic [3:0] rel_cnt_r;

    always_ff @(posedge aclk) begin
        lo_len_r <= scl_oe ? lo_len_r + 12'h001 : 12'h000;
        rel_cnt_r <= start ? 4'h0 : (scl_oe && (state_r == ITC_LOW) && ph_end) ? rel_cnt_r + 4'h1 : rel_cnt_r;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence srst_held;
        srst_busy_r [*4] ##1 !srst_busy_r;
    endsequence

    chk_monitor_reads_busy: assert property (srst_busy_r |-> !tcc_rd[0])
        else $error("reset monitor not low during soft reset");
    chk_reset_freq_code: assert property ($past(!aresetn) |-> sck_r == SCK_RST && tcc_rd[0])
        else $error("frequency code or monitor wrong after reset");
    chk_fixed_read_bits: assert property (tcc_rd[31:8] == 24'h0 && tcc_rd[TCC_ONE_BIT])
        else $error("fixed bits of length register read wrong");
    chk_soft_reset_run: assert property (srst_go && !srst_busy_r |=> srst_held)
        else $error("soft reset did not last its cycles");
    chk_soft_reset_gate: assert property (!srst_go && !srst_busy_r |=> !srst_busy_r)
        else $error("soft reset started without trigger sequence");
    chk_scl_low_half: assert property ($fell(scl_oe) |-> lo_len_r == half)
        else $error("scl low phase length wrong");
    chk_clock_count: assert property ($fell(m_busy) |-> rel_cnt_r == total_r)
        else $error("master transfer clock count wrong");
    chk_ack_released: assert property (m_busy && ack_lat_r && last_clk |-> !sda_oe)
        else $error("sda driven during acknowledge clock");
    chk_no_ack_count: assert property (start && !ack_r |=> total_r == itc_data_bits(bc_r))
        else $error("acknowledge clock added while disabled");

endmodule

// *** testbench/itc_far_model.sv ***
/*
 * itc_far_model: far party on the two-wire bus, slave that may
 * acknowledge, or master that clocks a frame on a 6 ns link clock.
 * Assumes the bench resolves both open-drain wires with pull-ups.
 */
`timescale 1ns/1ps
module itc_far_model (
    input wire logic scl, // scl wire level
    input wire logic sda, // sda wire level
    input wire logic ack_low, // pull sda low in the ack clock
    input wire logic [3:0] n_data, // data bits of a master frame
    output logic scl_low, // pulls scl low
    output logic sda_low // pulls sda low
);
    // ------------------------------------------------------------
    // slave role
    // ------------------------------------------------------------
    int fall_cnt = 0;
    logic got[$];
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    always @(negedge scl) begin
        fall_cnt = fall_cnt + 1;
        if (ack_low) sda_low = (fall_cnt == n_data + 1);
    end
    // sampled at each rising scl edge
    always @(posedge scl) got.push_back(sda);
    // ------------------------------------------------------------
    // master role: clock runs only inside the frame
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            scl_low = 1'b1;
            sda_low = (i < 8) ? ~v[7-i] : 1'b0;
            #3;
            scl_low = 1'b0;
            #3;
        end
        sda_low = 1'b0;
    endtask
endmodule

// *** testbench/tb.sv ***
/*
 * tb: self-checking bench for itc_top over AXI4-Lite and the bus wires.
 * Assumes itc_pkg offsets and the far model on resolved scl and sda.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import itc_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf, n_data = 4'h8;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, ack_low = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, scl_o, scl_oe, scl_low, sda_low;
    logic [1:0] bresp, rresp;
    logic [31:0] seed = 32'hf3ff;
    int n_mismatch = 0, tests_run = 0, lo_cnt = 0, lo_len = 0;
    wire scl_w = !(scl_oe | scl_low);
    wire sda_w = !(sda_oe | sda_low);

    itc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_clk(scl_w),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe));
    itc_far_model p (.scl(scl_w), .sda(sda_w), .ack_low(ack_low), .n_data(n_data),
        .scl_low(scl_low), .sda_low(sda_low));

    initial begin
        forever #5 aclk = ~aclk;
    end
    // length of the last scl low phase in system clocks
    always @(posedge aclk) begin
        if (scl_oe === 1'b1) lo_cnt <= lo_cnt + 1;
        else if (lo_cnt != 0) begin
            lo_len <= lo_cnt;
            lo_cnt <= 0;
        end
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // master frame: clock count, low phase, bit order, ack sample
    // ------------------------------------------------------------
    task automatic master_run(input int i);
        logic [2:0] bc, sck;
        logic ack;
        logic [1:0] r;
        logic [31:0] d;
        int nb;
        bc = 3'(i);
        ack = i[0];
        sck = 3'(i % 7);
        nb = (bc == 3'h0) ? 8 : i;
        if (i != 0) wr(OFS_TCC, {24'h0, bc, ack, 1'b0, sck}, r);
        seed = lfsr_next(seed);
        wr(OFS_DATA, {24'h0, seed[7:0]}, r);
        ack_low = seed[8];
        n_data = 4'(nb);
        p.fall_cnt = 0;
        p.got.delete();
        // start is honoured only once master mode already stands
        wr(OFS_CTRL, 32'h80, r);
        wr(OFS_CTRL, 32'hb0, r);
        do rd(OFS_CTRL, d, r); while (d[STAT_DONE_BIT] !== 1'b1);
        `CHK(p.got.size(), nb + ack);
        `CHK(lo_len, (2 ** (sck + 5) + 72) / 2);
        for (int k = 0; k < nb; k++) `CHK(p.got[k], seed[7-k]);
        if (ack) `CHK(d[0], ~seed[8]);
        `CHK({scl_o, sda_o, d[STAT_BUSY_BIT]}, 3'h0);
        rd(OFS_DATA, d, r);
        `CHK(d[7:0] & 8'(9'h1ff >> (9 - nb)), 8'(seed[7:0] >> (8 - nb)));
        ack_low = 1'b0;
        p.sda_low = 1'b0;
    endtask
    // ------------------------------------------------------------
    // slave frame: ack clock counted or not, received bits
    // ------------------------------------------------------------
    task automatic slave_run(input int i);
        logic [2:0] bc;
        logic ack;
        logic [1:0] r;
        logic [31:0] d;
        int nb;
        bc = 3'(i);
        ack = ~i[0];
        nb = (bc == 3'h0) ? 8 : i;
        wr(OFS_TCC, {24'h0, bc, ack, 4'h0}, r);
        // flush the slave clear through its link-side synchroniser
        wr(OFS_CTRL, 32'h80, r);
        p.send(8'hff, 3);
        wr(OFS_CTRL, 32'h0, r);
        p.send(8'hff, 2);
        repeat (5) @(posedge aclk);
        wr(OFS_CTRL, 32'h10, r);
        seed = lfsr_next(seed);
        p.send(seed[7:0], nb);
        repeat (20) @(posedge aclk);
        rd(OFS_CTRL, d, r);
        `CHK(d[STAT_DONE_BIT], !ack);
        if (ack) begin
            p.send(8'hff, 1);
            repeat (20) @(posedge aclk);
            rd(OFS_CTRL, d, r);
            `CHK(d[STAT_DONE_BIT], 1'b1);
        end
        rd(OFS_DATA, d, r);
        `CHK(d[7:0] & 8'(9'h1ff >> (9 - nb)), 8'(seed[7:0] >> (8 - nb)));
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        logic [1:0] r;
        logic [31:0] d, m;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_TCC, d, r);
        `CHK(d, 32'h0000_0009);
        for (int i = 0; i < 8; i++) master_run(i);
        for (int i = 0; i < 8; i++) slave_run(i);
        rd(8'h0c, d, r);
        `CHK({r, d}, {RESP_SLVERR, 32'h0});
        wr(8'h0c, 32'hff, r);
        `CHK(r, RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr_next(seed);
            wr(OFS_TCC, seed, r);
            m = {24'h0, seed[7:4], 1'b1, seed[2:1], 1'b1};
            rd(OFS_TCC, d, r);
            `CHK(d, m);
        end
        wr(OFS_CTRL, {30'h0, SRST_ARM}, r);
        wr(OFS_CTRL, {30'h0, SRST_FIRE}, r);
        rd(OFS_TCC, d, r);
        `CHK(d[0], 1'b0);
        repeat (8) @(posedge aclk);
        rd(OFS_TCC, d, r);
        `CHK(d, m);
        wr(OFS_CTRL, {30'h0, SRST_ARM}, r);
        wr(OFS_CTRL, 32'h0, r);
        wr(OFS_CTRL, {30'h0, SRST_FIRE}, r);
        rd(OFS_TCC, d, r);
        `CHK(d[0], 1'b1);
        wr(OFS_TCC, 32'h0, r);
        rd(OFS_TCC, d, r);
        `CHK(d, 32'h0000_0009);
        give_verdict;
    end
    initial begin
        repeat (100000) @(posedge aclk);
        n_mismatch++;
        give_verdict;
    end
endmodule
